// [bench/crystal_model.sv]
// External crystal or clock source model
`timescale 1ns/100ps
module crystal_model (
    input wire logic run,
    input wire logic [31:0] half_ns,
    output logic ext_ref_in
);
    initial begin
        ext_ref_in = 1'b0;
        forever begin
            #(half_ns);
            if (run) begin
                ext_ref_in = ~ext_ref_in;
            end else begin
                ext_ref_in = 1'b0;
            end
        end
    end
endmodule // crystal_model

// [bench/tb.sv]
// Self-checking bench for the clock source mode control
`timescale 1ns/100ps
`include "clock_defines.svh"
module tb;
    logic pclk, presetn, por_n, psel, penable, pwrite, stop_mode, run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, ext_ref_in, mco, bco, aic, aec, pll_en, e2l, srq;
    logic llc, fen, osen, high_gain_select;
    logic [4:0] pv;
    logic [33:0] expq[$];
    logic [33:0] e;
    int failures, check_count, n, cm, cb, ci, ce, cl, a, b, seed;
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    crystal_model osc_u (.run(run), .half_ns(125), .ext_ref_in(ext_ref_in));
    clock_source_mode_control dut_u (.pclk(pclk), .presetn(presetn),
        .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_ref_in(ext_ref_in), .stop_mode(stop_mode),
        .main_clock_out(mco), .bus_clock_out(bco), .locked_loop_clock(llc),
        .aux_internal_clock(aic), .aux_external_clock(aec),
        .fll_enable(fen), .pll_enable(pll_en), .osc_enable(osen),
        .osc_high_gain(high_gain_select), .ext_to_loops(e2l), .system_reset_req(srq));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One APB transfer; tag bit 33 marks a compared answer
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, input logic [33:0] x);
        int k;
        k = 0;
        expq.push_back(x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk) begin
        if (pready === 1'b1) begin
            e = expq.pop_front();
            if (e[33]) begin
                check({pslverr, prdata}, e[32:0]);
            end
        end
        cm += (mco === 1'b1 && pv[4] === 1'b0);
        cb += (bco === 1'b1 && pv[3] === 1'b0);
        ci += (aic === 1'b1 && pv[2] === 1'b0);
        ce += (aec === 1'b1 && pv[1] === 1'b0);
        cl += (llc === 1'b1 && pv[0] === 1'b0);
        pv <= {mco, bco, aic, aec, llc};
    end
    task automatic rchk(input logic [7:0] ad, input logic [32:0] x);
        apb(1'b0, ad, 32'h0, {1'b1, x});
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b1, ad, {24'h0, d}, 34'h0);
    endtask
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        {psel, penable, pwrite, stop_mode, run} = 5'h00;
        {paddr, pwdata, failures, check_count} = '0;
        {cm, cb, ci, ce, cl} = '0;
        presetn = 1'b0;
        por_n = 1'b0;
        seed = 32'he57f;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        rchk(`CTL1_OFS, {1'b0, 32'h00000004});
        rchk(`CTL2_OFS, 33'h0);
        rchk(`TRIM_OFS, {1'b0, 32'h00000080});
        rchk(8'h1C, {1'b1, 32'h0});
        a = $random(seed);
        wr(`TRIM_OFS, a[7:0]);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(`TRIM_OFS, {25'h0, a[7:0]});
        // larger trim, slower internal aux clock
        wr(`CTL1_OFS, 8'h46);
        wr(`TRIM_OFS, 8'h00);
        a = ci;
        repeat (3000) @(posedge pclk);
        a = ci - a;
        wr(`TRIM_OFS, 8'hFF);
        b = ci;
        repeat (3000) @(posedge pclk);
        b = ci - b;
        check(a > b && b > 0, 33'h1);
        wr(`TRIM_OFS, 8'h00);
        wr(`CTL1_OFS, 8'h07);
        stop_mode <= 1'b1;
        a = ci;
        repeat (1000) @(posedge pclk);
        check(ci > a, 33'h1);
        stop_mode <= 1'b0;
        run <= 1'b1;
        wr(`CTL2_OFS, 8'h36);
        rchk(`CTL2_OFS, {25'h0, 8'h36});
        check(high_gain_select, 33'h1);
        n = 0;
        do begin
            apb(1'b0, `STAT_OFS, 32'h0, 34'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 400);
        check(rd[1], 33'h1);
        a = ce;
        repeat (200) @(posedge pclk);
        check(ce > a, 33'h1);
        wr(`CTL1_OFS, 8'hB8);
        repeat (4) @(posedge pclk);
        check({e2l, pll_en, fen}, 33'h5);
        // bus clock half of main, two dividers
        for (int dv = 0; dv < 2; dv++) begin
            wr(`CTL2_OFS, {dv[1:0], 6'h36});
            a = cm;
            b = cb;
            n = cl;
            repeat (2000) @(posedge pclk);
            a = cm - a;
            b = cb - b;
            check(a > 4 && b * 2 >= a - 2 && b * 2 <= a + 2, 33'h1);
            check(cl > n, 33'h1);
        end
        // low power bit turns loops off
        wr(`CTL2_OFS, 8'h3E);
        repeat (4) @(posedge pclk);
        check({fen, pll_en}, 33'h0);
        stop_mode <= 1'b1;
        repeat (4) @(posedge pclk);
        check(osen, 33'h1);
        stop_mode <= 1'b0;
        // loss of clock with monitor on
        wr(`CTL3_OFS, 8'h21);
        run <= 1'b0;
        n = 0;
        while (srq !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        check(srq, 33'h1);
        rchk(`RST_OFS, {25'h0, 8'h01});
        // PLL engaged entry with source running
        run <= 1'b1;
        wr(`CTL3_OFS, 8'h40);
        wr(`CTL1_OFS, 8'h08);
        repeat (4) @(posedge pclk);
        check(pll_en, 33'h1);
        report_and_stop();
    end
endmodule // tb

// [logic/clock_defines.svh]
// Register map, field positions, reset values and timing counts
`ifndef CLOCK_DEFINES_SVH
`define CLOCK_DEFINES_SVH
`define CTL1_OFS 8'h00
`define CTL2_OFS 8'h04
`define TRIM_OFS 8'h08
`define STAT_OFS 8'h0C
`define CTL3_OFS 8'h10
`define FINE_TRIM_OFS 8'h14
`define RST_OFS 8'h18
`define CTL1_RESET 8'h04
`define CTL2_RESET 8'h00
`define CTL3_RESET 8'h01
`define TRIM_RESET 8'h80
`define FINE_TRIM_RESET 1'b0
`define SRC_POS 6
`define REFERENCE_DIVIDER_POS 3
`define INTERNAL_REF_SELECT_BIT 2
`define IREN_BIT 1
`define IRSTOP_BIT 0
`define BUS_DIVIDER_POS 6
`define RANGE_BIT 5
`define HGO_BIT 4
`define LP_BIT 3
`define CRYSTAL_SELECT_BIT 2
`define EREN_BIT 1
`define ERSTOP_BIT 0
`define LOOP_SELECT_BIT 6
`define CME_BIT 5
`define MULT_POS 0
`define FLOCK_BIT 3
`define PLOCK_BIT 2
`define OSCRDY_BIT 1
`define IREFST_BIT 0
`define LOSS_BIT 0
`define CLK_NS 5
`define LOC_HIGH_NS 1000
`define LOC_LOW_NS 16000
`define LOC_HIGH_CYC (`LOC_HIGH_NS / `CLK_NS)
`define LOC_LOW_CYC (`LOC_LOW_NS / `CLK_NS)
`define OSC_EDGES 5'h10
`define LOCK_REFS 4'h8
`define INT_BASE 10'h040
`define FLL_EXT_TOP 4'h3
`define LOOP_MULT 9'h400
`endif

// [logic/clock_pkg.sv]
// Clock mode type
package clock_pkg;
    typedef enum logic [2:0] {
        internal_engaged,
        external_engaged,
        internal_bypassed,
        external_bypassed,
        pll_engaged,
        pll_bypassed,
        low_power_internal,
        low_power_external
    } mode_type;
endpackage

// [logic/clock_source_mode_control.sv]
// Clock source mode control with APB registers
// How it works
// RULE1 - Internal bypassed mode drives main clock from internal reference
// RULE2 - External bypassed mode drives main clock from external reference
// RULE3 - Source 10, internal select 0, loop select 0, low power 0: ext bypass
// RULE4 - Source 00, internal select 0, loop select 1: PLL engaged mode
// RULE5 - FLL bypassed modes: locked clock from FLL, PLL held off; with loop select set the code takes it from the idle PLL
// RULE6 - Bus divider change takes effect at once
// RULE7 - Low power bit turns unused loops off; cleared keeps the loop picked by loop select on, bar PLL in FLL bypassed modes
// RULE8 - Internal enable presents internal reference as aux clock
// RULE9 - Larger trim gives longer internal reference period
// RULE10 - Trim reaches main clock only in internal modes
// RULE11 - Trim values reset only by power-on reset
// RULE12 - Internal stop enable with enable keeps reference running in stop
// RULE13 - External enable presents aux clock; internal select blocks loops
// RULE14 - External reference kept in stop when enabled with stop enable, or in use
// RULE15 - Clock monitor flags loss and resets system below threshold
// RULE16 - Bus clock is half the main clock
// RULE17 - Engaged modes use loop ticks, bypass modes the reference tick without the reference divider
// RULE18 - Reset starts in internal engaged mode, divider field zero
// RULE19 - Second control register holds divider, range, gain, select, enable
// RULE20 - Oscillator ready flag set once crystal runs; software polls it
// RULE21 - Software avoids PLL modes below 1 MHz external clock
`timescale 1ns/100ps
`include "clock_defines.svh"
module clock_source_mode_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_ref_in,
    input wire logic stop_mode,
    output logic main_clock_out,
    output logic bus_clock_out,
    output logic locked_loop_clock,
    output logic aux_internal_clock,
    output logic aux_external_clock,
    output logic fll_enable,
    output logic pll_enable,
    output logic osc_enable,
    output logic osc_high_gain,
    output logic ext_to_loops,
    output logic system_reset_req
);
    logic [7:0] ctl1_q, ctl2_q, ctl3_q, trim_q, prdata_q, stat;
    logic fine_trim_q, pready_q, pslverr_q, loss_q, reset_req_q;
    clock_pkg::mode_type mode_q;
    logic ext_s1_q, ext_s2_q, ext_prev_q, ext_tick_q, ext_div_tick_q;
    logic [7:0] ext_div_cnt_q, rtop;
    logic [9:0] int_cnt_q, int_period;
    logic int_tick_q, int_run, ext_keep;
    logic [3:0] fll_cnt_q, pll_cnt_q, fll_top, pll_top;
    logic fll_tick_q, pll_tick_q, ref_tick, sel_tick;
    logic [3:0] fll_lock_q, pll_lock_q;
    logic fll_en_q, pll_en_q, osc_en_q, main_q, bus_q, llc_q;
    logic aux_int_q, aux_ext_q, to_loops_q;
    logic [4:0] osc_cnt_q;
    logic osc_rdy_q;
    logic [11:0] loc_cnt_q, loc_limit;
    logic loss_set, setup, acc, wr, fll_byp, lp, internal_ref_select, loop_select;
    divider_if dif ();

    function automatic clock_pkg::mode_type decode_mode(
        input logic [1:0] src, input logic ir, input logic pl,
        input logic low);
        clock_pkg::mode_type m;
        m = clock_pkg::internal_engaged;
        if (src == 2'b00) begin
            if (ir) m = clock_pkg::internal_engaged;
            else if (pl) m = clock_pkg::pll_engaged;
            else m = clock_pkg::external_engaged;
        end else if (src == 2'b01) begin
            if (low) m = clock_pkg::low_power_internal;
            else m = clock_pkg::internal_bypassed;
        end else if (src == 2'b10) begin
            if (low) m = clock_pkg::low_power_external;
            else if (pl) m = clock_pkg::pll_bypassed;
            else m = clock_pkg::external_bypassed;
        end
        return m;
    endfunction

    function automatic logic uses_ext(input clock_pkg::mode_type m);
        return m == clock_pkg::external_engaged
            || m == clock_pkg::external_bypassed
            || m == clock_pkg::pll_engaged
            || m == clock_pkg::pll_bypassed
            || m == clock_pkg::low_power_external;
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        return a == `CTL1_OFS || a == `CTL2_OFS || a == `TRIM_OFS
            || a == `STAT_OFS || a == `CTL3_OFS || a == `FINE_TRIM_OFS
            || a == `RST_OFS;
    endfunction

    function automatic logic [3:0] lock_next(input logic en,
        input logic tick, input logic [3:0] cnt);
        if (!en) return 4'h0;
        if (tick && cnt != `LOCK_REFS) return cnt + 4'h1;
        return cnt;
    endfunction

    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite & ~pslverr_q;
    assign lp = ctl2_q[`LP_BIT];
    assign internal_ref_select = ctl1_q[`INTERNAL_REF_SELECT_BIT];
    assign loop_select = ctl3_q[`LOOP_SELECT_BIT];
    assign fll_byp = mode_q == clock_pkg::internal_bypassed
        || mode_q == clock_pkg::external_bypassed;

    // APB handshake, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 8'h00;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= ~reg_hit(paddr);
                prdata_q <= 8'h00;
                unique case (paddr)
                    `CTL1_OFS: prdata_q <= ctl1_q;
                    `CTL2_OFS: prdata_q <= ctl2_q;
                    `TRIM_OFS: prdata_q <= trim_q;
                    `STAT_OFS: prdata_q <= stat;
                    `CTL3_OFS: prdata_q <= ctl3_q;
                    `FINE_TRIM_OFS: prdata_q <= {7'h00, fine_trim_q};
                    `RST_OFS: prdata_q <= {7'h00, loss_q};
                    default: prdata_q <= 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        stat = 8'h00;
        stat[`FLOCK_BIT] = fll_lock_q == `LOCK_REFS;
        stat[`PLOCK_BIT] = pll_lock_q == `LOCK_REFS;
        // RULE20 - ready flag readable
        stat[`OSCRDY_BIT] = osc_rdy_q;
        stat[`IREFST_BIT] = internal_ref_select;
    end

    // RULE18 RULE19 - control reset and layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_q <= `CTL1_RESET;
            ctl2_q <= `CTL2_RESET;
            ctl3_q <= `CTL3_RESET;
        end else if (wr) begin
            if (paddr == `CTL1_OFS) ctl1_q <= pwdata[7:0];
            if (paddr == `CTL2_OFS) ctl2_q <= pwdata[7:0];
            if (paddr == `CTL3_OFS) ctl3_q <= pwdata[7:0];
        end
    end

    // RULE11 - trim on power-on only
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            trim_q <= `TRIM_RESET;
            fine_trim_q <= `FINE_TRIM_RESET;
        end else if (wr) begin
            if (paddr == `TRIM_OFS) trim_q <= pwdata[7:0];
            if (paddr == `FINE_TRIM_OFS) fine_trim_q <= pwdata[0];
        end
    end

    // RULE3 RULE4 - mode decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= clock_pkg::internal_engaged;
        end else begin
            mode_q <= decode_mode(ctl1_q[`SRC_POS +: 2], internal_ref_select, loop_select, lp);
        end
    end

    // External pin synchroniser and edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
            ext_tick_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_ref_in;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            ext_tick_q <= ext_s2_q & ~ext_prev_q;
        end
    end

    // RULE17 - reference divider on external ticks
    assign rtop = (8'h01 << ctl1_q[`REFERENCE_DIVIDER_POS +: 3]) - 8'h01;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_div_cnt_q <= 8'h00;
            ext_div_tick_q <= 1'b0;
        end else begin
            ext_div_tick_q <= 1'b0;
            if (ext_tick_q) begin
                if (ext_div_cnt_q >= rtop) begin
                    ext_div_cnt_q <= 8'h00;
                    ext_div_tick_q <= 1'b1;
                end else begin
                    ext_div_cnt_q <= ext_div_cnt_q + 8'h01;
                end
            end
        end
    end

    // RULE9 - trim stretches period
    assign int_period = `INT_BASE + {1'b0, trim_q, fine_trim_q};
    // RULE12 - internal reference in stop
    assign int_run = ~stop_mode
        | (ctl1_q[`IREN_BIT] & ctl1_q[`IRSTOP_BIT]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_cnt_q <= 10'h000;
            int_tick_q <= 1'b0;
        end else begin
            int_tick_q <= 1'b0;
            if (int_run) begin
                if (int_cnt_q >= int_period - 10'h001) begin
                    int_cnt_q <= 10'h000;
                    int_tick_q <= 1'b1;
                end else begin
                    int_cnt_q <= int_cnt_q + 10'h001;
                end
            end
        end
    end

    // RULE13 - external feeds loops only without internal select
    assign ref_tick = internal_ref_select ? int_tick_q : ext_div_tick_q;
    // RULE10 - trim reaches FLL only on internal reference
    assign fll_top = internal_ref_select ? int_period[9:6] : `FLL_EXT_TOP;
    assign pll_top = 4'hF - ctl3_q[`MULT_POS +: 4];

    // Loop tick generators and lock counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fll_cnt_q <= 4'h0;
            pll_cnt_q <= 4'h0;
            fll_tick_q <= 1'b0;
            pll_tick_q <= 1'b0;
        end else begin
            fll_tick_q <= fll_en_q && fll_cnt_q >= fll_top;
            pll_tick_q <= pll_en_q && pll_cnt_q >= pll_top;
            if (!fll_en_q || fll_cnt_q >= fll_top) fll_cnt_q <= 4'h0;
            else fll_cnt_q <= fll_cnt_q + 4'h1;
            if (!pll_en_q || pll_cnt_q >= pll_top) pll_cnt_q <= 4'h0;
            else pll_cnt_q <= pll_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fll_lock_q <= 4'h0;
            pll_lock_q <= 4'h0;
        end else begin
            fll_lock_q <= lock_next(fll_en_q, ref_tick, fll_lock_q);
            pll_lock_q <= lock_next(pll_en_q, ref_tick, pll_lock_q);
        end
    end

    // RULE5 RULE7 - loop enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fll_en_q <= 1'b1;
            pll_en_q <= 1'b0;
        end else begin
            fll_en_q <= ~stop_mode & ((~loop_select & ~lp)
                | mode_q == clock_pkg::internal_engaged
                | mode_q == clock_pkg::external_engaged);
            pll_en_q <= ~stop_mode & ((loop_select & ~lp & ~fll_byp)
                | mode_q == clock_pkg::pll_engaged);
        end
    end

    // RULE1 RULE2 RULE17 - main source select
    always_comb begin
        unique case (mode_q)
            clock_pkg::internal_engaged: sel_tick = fll_tick_q;
            clock_pkg::external_engaged: sel_tick = fll_tick_q;
            clock_pkg::pll_engaged: sel_tick = pll_tick_q;
            clock_pkg::internal_bypassed: sel_tick = int_tick_q;
            clock_pkg::low_power_internal: sel_tick = int_tick_q;
            clock_pkg::external_bypassed: sel_tick = ext_tick_q;
            clock_pkg::pll_bypassed: sel_tick = ext_tick_q;
            clock_pkg::low_power_external: sel_tick = ext_tick_q;
        endcase
    end

    assign dif.tick_in = sel_tick;
    // RULE6 - divisor straight from register
    assign dif.divisor = 4'h1 << ctl2_q[`BUS_DIVIDER_POS +: 2];
    tick_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .dif(dif)
    );

    // RULE16 - bus toggles on main rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_q <= 1'b0;
            bus_q <= 1'b0;
        end else if (dif.tick_out) begin
            main_q <= ~main_q;
            if (!main_q) bus_q <= ~bus_q;
        end
    end

    // RULE5 RULE8 RULE13 - derived clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            llc_q <= 1'b0;
            aux_int_q <= 1'b0;
            aux_ext_q <= 1'b0;
            to_loops_q <= 1'b0;
        end else begin
            if (loop_select ? pll_tick_q : fll_tick_q) llc_q <= ~llc_q;
            if (!ctl1_q[`IREN_BIT]) aux_int_q <= 1'b0;
            else if (int_tick_q) aux_int_q <= ~aux_int_q;
            aux_ext_q <= ctl2_q[`EREN_BIT] & ext_s2_q;
            to_loops_q <= ~internal_ref_select;
        end
    end

    // RULE14 - oscillator kept in stop
    assign ext_keep = (ctl2_q[`EREN_BIT] & ctl2_q[`ERSTOP_BIT])
        | uses_ext(mode_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_en_q <= 1'b0;
        end else begin
            osc_en_q <= (ctl2_q[`EREN_BIT] | uses_ext(mode_q))
                & (~stop_mode | ext_keep);
        end
    end

    // RULE20 - oscillator start count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 5'h00;
            osc_rdy_q <= 1'b0;
        end else if (!osc_en_q) begin
            osc_cnt_q <= 5'h00;
            osc_rdy_q <= 1'b0;
        end else begin
            if (ext_tick_q && osc_cnt_q != `OSC_EDGES)
                osc_cnt_q <= osc_cnt_q + 5'h01;
            osc_rdy_q <= osc_cnt_q == `OSC_EDGES;
        end
    end

    // RULE15 - clock monitor
    assign loc_limit = ctl2_q[`RANGE_BIT] ? 12'(`LOC_HIGH_CYC)
        : 12'(`LOC_LOW_CYC);
    assign loss_set = ctl3_q[`CME_BIT] && loc_cnt_q == loc_limit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loc_cnt_q <= 12'h000;
            reset_req_q <= 1'b0;
            loss_q <= 1'b0;
        end else begin
            if (!ctl3_q[`CME_BIT] || ext_tick_q) loc_cnt_q <= 12'h000;
            else if (loc_cnt_q != 12'hFFF) loc_cnt_q <= loc_cnt_q + 12'h001;
            reset_req_q <= loss_set;
            loss_q <= loss_set | (loss_q & ~(wr && paddr == `RST_OFS
                && pwdata[`LOSS_BIT]));
        end
    end

    assign prdata = {24'h000000, prdata_q};
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign main_clock_out = main_q;
    assign bus_clock_out = bus_q;
    assign locked_loop_clock = llc_q;
    assign aux_internal_clock = aux_int_q;
    assign aux_external_clock = aux_ext_q;
    assign fll_enable = fll_en_q;
    assign pll_enable = pll_en_q;
    assign osc_enable = osc_en_q;
    assign osc_high_gain = ctl2_q[`HGO_BIT];
    assign ext_to_loops = to_loops_q;
    assign system_reset_req = reset_req_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fbe_cfg;
        ctl1_q[`SRC_POS +: 2] == 2'b10 && !internal_ref_select && !loop_select && !lp;
    endsequence
    sequence s_pee_cfg;
        ctl1_q[`SRC_POS +: 2] == 2'b00 && !internal_ref_select && loop_select;
    endsequence
    sequence s_osc_done;
        osc_en_q ##0 osc_cnt_q == `OSC_EDGES;
    endsequence

    property p_fbi_src;
        mode_q == clock_pkg::internal_bypassed && int_tick_q
            && dif.divisor == 4'h1 |-> ##2 $changed(main_q);
    endproperty
    a_fbi_src: assert property (p_fbi_src) else $error("fbi source"); // RULE1
    property p_fbe_src;
        mode_q == clock_pkg::external_bypassed && ext_tick_q
            && dif.divisor == 4'h1 |-> ##2 $changed(main_q);
    endproperty
    a_fbe_src: assert property (p_fbe_src) else $error("fbe source"); // RULE2
    property p_fbe_entry;
        s_fbe_cfg |=> mode_q == clock_pkg::external_bypassed;
    endproperty
    a_fbe_entry: assert property (p_fbe_entry) else $error("fbe"); // RULE3
    property p_pee_entry;
        s_pee_cfg |=> mode_q == clock_pkg::pll_engaged;
    endproperty
    a_pee_entry: assert property (p_pee_entry) else $error("pee"); // RULE4
    property p_byp_pll_off;
        fll_byp |=> !pll_en_q;
    endproperty
    a_byp_pll_off: assert property (p_byp_pll_off) else $error("pll on"); // RULE5
    property p_lp_off;
        lp && mode_q != clock_pkg::pll_engaged
            && mode_q != clock_pkg::internal_engaged
            && mode_q != clock_pkg::external_engaged
            |=> !fll_en_q && !pll_en_q;
    endproperty
    a_lp_off: assert property (p_lp_off) else $error("lp loop on"); // RULE7
    property p_aux_int_off;
        !ctl1_q[`IREN_BIT] |=> !aux_int_q;
    endproperty
    a_aux_int_off: assert property (p_aux_int_off) else $error("aux"); // RULE8
    property p_loc;
        loss_set |=> loss_q && reset_req_q;
    endproperty
    a_loc: assert property (p_loc) else $error("loss of clock"); // RULE15
    property p_bus_half;
        $changed(bus_q) |-> $rose(main_q);
    endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus clock"); // RULE16
    property p_osc_ready;
        s_osc_done |=> osc_rdy_q || !osc_en_q;
    endproperty
    a_osc_ready: assert property (p_osc_ready) else $error("osc"); // RULE20
endmodule // clock_source_mode_control

// [logic/divider_if.sv]
// Tick path between mode control and bus divider
`timescale 1ns/100ps
interface divider_if;
    logic tick_in;
    logic [3:0] divisor;
    logic tick_out;
    modport user (output tick_in, output divisor, input tick_out);
    modport divider (input tick_in, input divisor, output tick_out);
endinterface

// [logic/tick_divider.sv]
// Bus divider on source ticks
`timescale 1ns/100ps
module tick_divider (
    input wire logic pclk,
    input wire logic presetn,
    divider_if.divider dif
);
    logic [3:0] cnt_q;
    logic tick_q;

    // RULE6 - live divisor compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (dif.tick_in) begin
                if (cnt_q + 4'h1 >= dif.divisor) begin
                    cnt_q <= 4'h0;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

    assign dif.tick_out = tick_q;
endmodule // tick_divider
